/* rtl/dwsp_host.sv */
`timescale 1ns/1ps
module dwsp_host
  import dwsp_pkg::*;
#(
  parameter int DEV_COUNT = 1
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  dwsp_if.host LINK,
  input wire logic START_I,
  input wire logic [SHIFT_LEN*DEV_COUNT-1:0] TX_DATA_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [SHIFT_LEN*DEV_COUNT-1:0] RX_DATA_O
);
  localparam int NBITS = SHIFT_LEN * DEV_COUNT;
  localparam int CW = $clog2(NBITS + 1);
  //////////////////////////////////////////////////////////////////////
  logic cas_m_r;
  logic cas_s_r;
  dwsp_host_state_t st_r;
  dwsp_host_state_t st_nxt;
  logic [NBITS-1:0] tx_r;
  logic [NBITS-1:0] tx_nxt;
  logic [NBITS-1:0] rx_r;
  logic [NBITS-1:0] rx_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [LINK_DIV_W-1:0] div_r;
  logic [LINK_DIV_W-1:0] div_nxt;
  logic sel_r;
  logic sel_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic done_r;
  logic done_nxt;
  logic tick;
  assign tick = (div_r == LINK_DIV_W'(LINK_DIV - 1));
  always_comb begin
    st_nxt = st_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    sel_nxt = sel_r;
    sclk_nxt = sclk_r;
    done_nxt = 1'b0;
    div_nxt = tick ? '0 : div_r + 1'b1;
    case (st_r)
      HS_IDLE: begin
        div_nxt = '0;
        if (START_I) begin
          tx_nxt = TX_DATA_I; // [R8]
          cnt_nxt = CW'(NBITS); // [R9] [R16]
          sel_nxt = 1'b1; // [R2]
          st_nxt = HS_SEL;
        end
      end
      HS_SEL: if (tick) st_nxt = HS_LOW;
      HS_LOW: begin
        if (tick) begin
          if (cnt_r == '0) begin
            sel_nxt = 1'b0; // [R10]
            st_nxt = HS_END;
          end else begin
            sclk_nxt = 1'b1; // [R3]
            rx_nxt = {rx_r[NBITS-2:0], cas_s_r};
            st_nxt = HS_HIGH;
          end
        end
      end
      HS_HIGH: begin
        if (tick) begin
          sclk_nxt = 1'b0;
          tx_nxt = {tx_r[NBITS-2:0], 1'b0};
          cnt_nxt = cnt_r - 1'b1;
          st_nxt = HS_LOW;
        end
      end
      HS_END: begin
        if (tick) begin
          done_nxt = 1'b1;
          st_nxt = HS_IDLE;
        end
      end
      default: st_nxt = HS_IDLE;
    endcase
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cas_m_r <= 1'b0;
      cas_s_r <= 1'b0;
      st_r <= HS_IDLE;
      tx_r <= '0;
      rx_r <= '0;
      cnt_r <= '0;
      div_r <= '0;
      sel_r <= 1'b0;
      sclk_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cas_m_r <= LINK.cascade_out;
      cas_s_r <= cas_m_r;
      st_r <= st_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      sel_r <= sel_nxt;
      sclk_r <= sclk_nxt;
      done_r <= done_nxt;
    end
  end
  assign LINK.sel = sel_r;
  assign LINK.sclk = sclk_r;
  assign LINK.sdata = tx_r[NBITS-1];
  assign BUSY_O = (st_r != HS_IDLE);
  assign DONE_O = done_r;
  assign RX_DATA_O = rx_r;
endmodule : dwsp_host

/* rtl/dwsp_pkg.sv */
package dwsp_pkg;
  localparam int SHIFT_LEN = 17;
  localparam int WIPER_W = 8;
  localparam int STACK_POS = 0;
  localparam int SECOND_MSB_POS = 1;
  localparam int FIRST_MSB_POS = 9;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic STACK_RESET = 1'b0;
  localparam int LINK_DIV = 4;
  localparam int LINK_DIV_W = 3;
  typedef enum {HS_IDLE, HS_SEL, HS_LOW, HS_HIGH, HS_END} dwsp_host_state_t;
endpackage : dwsp_pkg

/* rtl/dwsp_if.sv */
`timescale 1ns/1ps
interface dwsp_if;
  logic sel;
  logic sclk;
  logic sdata;
  logic cascade_out;
  modport device (input sel, input sclk, input sdata, output cascade_out);
  modport host (output sel, output sclk, output sdata, input cascade_out);
endinterface : dwsp_if

/* rtl/dwsp_device.sv */
`timescale 1ns/1ps
// Contract
// [R1] ignore clock and data while deselected
// [R2] host raises select before any clock
// [R3] sample data on rising serial clock
// [R4] seventeen bit register: stack, two wipers
// [R5] position zero holds stack select
// [R6] positions one to eight: second wiper
// [R7] positions nine to sixteen: first wiper
// [R8] host sends stack, second, first, MSB first
// [R9] host clocks multiples of seventeen bits
// [R10] host drops select after transaction
// [R11] apply register when select falls
// [R12] reset wipers to mid-scale
// [R13] stack bit picks first or second wiper
// [R14] cascade shows last stage, stack first
// [R15] cascade always driven, select independent
// [R16] host clocks seventeen bits per device
// [R17] shift one place per selected rising edge
module dwsp_device
  import dwsp_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  dwsp_if.device LINK,
  output logic [WIPER_W-1:0] FIRST_WIPER_O,
  output logic [WIPER_W-1:0] SECOND_WIPER_O,
  output logic STACK_SEL_O,
  output logic [WIPER_W-1:0] STACKED_WIPER_OUT_O
);
  //////////////////////////////////////////////////////////////////////
  // two-flop synchronisers on the link inputs
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] meta_nxt;
  logic [2:0] sync_nxt;
  logic sel_d_r;
  logic sclk_d_r;
  logic sel_d_nxt;
  logic sclk_d_nxt;
  always_comb begin
    meta_nxt = {LINK.sel, LINK.sclk, LINK.sdata};
    sync_nxt = meta_r;
    sel_d_nxt = sync_r[2];
    sclk_d_nxt = sync_r[1];
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      sel_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      sel_d_r <= sel_d_nxt;
      sclk_d_r <= sclk_d_nxt;
    end
  end
  logic sel_s;
  logic shift_ev;
  logic apply_ev;
  assign sel_s = sync_r[2];
  assign shift_ev = sel_s && sync_r[1] && !sclk_d_r; // [R1] [R3]
  assign apply_ev = sel_d_r && !sel_s; // [R11]
  //////////////////////////////////////////////////////////////////////
  // shift register and applied wiper state
  logic [SHIFT_LEN-1:0] shreg_r;
  logic [SHIFT_LEN-1:0] shreg_nxt;
  logic [WIPER_W-1:0] first_r;
  logic [WIPER_W-1:0] second_r;
  logic stack_r;
  logic [WIPER_W-1:0] first_nxt;
  logic [WIPER_W-1:0] second_nxt;
  logic stack_nxt;
  always_comb begin
    shreg_nxt = shreg_r;
    first_nxt = first_r;
    second_nxt = second_r;
    stack_nxt = stack_r;
    if (shift_ev) begin
      shreg_nxt = {shreg_r[SHIFT_LEN-2:0], sync_r[0]}; // [R17] [R4]
    end
    if (apply_ev) begin
      stack_nxt = shreg_r[SHIFT_LEN-1-STACK_POS]; // [R5]
      second_nxt = shreg_r[SHIFT_LEN-1-SECOND_MSB_POS -: WIPER_W]; // [R6]
      first_nxt = shreg_r[SHIFT_LEN-1-FIRST_MSB_POS -: WIPER_W]; // [R7]
    end
  end
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shreg_r <= {STACK_RESET, WIPER_RESET, WIPER_RESET};
      first_r <= WIPER_RESET; // [R12]
      second_r <= WIPER_RESET; // [R12]
      stack_r <= STACK_RESET;
    end else begin
      shreg_r <= shreg_nxt;
      first_r <= first_nxt;
      second_r <= second_nxt;
      stack_r <= stack_nxt;
    end
  end
  // oldest bit (stack select after a full load) sits at the top
  assign LINK.cascade_out = shreg_r[SHIFT_LEN-1]; // [R14] [R15]
  assign FIRST_WIPER_O = first_r;
  assign SECOND_WIPER_O = second_r;
  assign STACK_SEL_O = stack_r;
  assign STACKED_WIPER_OUT_O = stack_r ? second_r : first_r; // [R13]
endmodule : dwsp_device

/* dv/dwsp_assertions.sv */
`timescale 1ns/1ps
module dwsp_assertions #(
  parameter int DEV_COUNT = 1
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic sel,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic cascade_out
);
  logic [7:0] rises_r;
  logic sclk_r;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rises_r <= 8'h00;
      sclk_r <= 1'b0;
    end else begin
      sclk_r <= sclk;
      rises_r <= !sel ? 8'h00 : rises_r + 8'(sclk && !sclk_r);
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_high;
    sclk [*4];
  endsequence
  sequence s_quiet;
    !sclk [*4];
  endsequence
  a_idle_clock_low: assert property (!sel |-> !sclk) else $error("clock moved while deselected");
  a_select_lead: assert property ($rose(sel) |-> s_quiet) else $error("clock too soon after select");
  a_clock_high_time: assert property ($rose(sclk) |-> s_high ##1 !sclk) else $error("bad high phase");
  a_data_hold_high: assert property (sclk ##1 sclk |-> $stable(sdata)) else $error("data moved");
  a_frame_length: assert property ($fell(sel) |-> rises_r == 8'(17 * DEV_COUNT)) else $error("bit count");
  a_select_spans_clock: assert property ($rose(sclk) |-> sel throughout s_high) else $error("select dropped");
  a_quiet_deselect: assert property (!sel [*4] |-> $stable(cascade_out)) else $error("cascade moved");
  a_shift_after_rise: assert property ($changed(cascade_out) |-> $past(sclk, 3) && !$past(sclk, 4))
    else $error("cascade moved off a clock rise");
endmodule : dwsp_assertions

/* dv/tb_dual_wiper_serial_shift_port.sv */
`timescale 1ns/1ps
module tb_dual_wiper_serial_shift_port;
  import dwsp_pkg::*;
  logic clk = 0, rst = 1, start = 0, done, busy, ss, ss2;
  logic [16:0] tx = 17'h00000, rx, prev = 17'h08080;
  logic [7:0] fw, sw, ow, fw2, sw2, ow2;
  int miscompares = 0, checks_done = 0, seed = 43;
  dwsp_if link();
  dwsp_if rogue();
  always #12.5 clk = ~clk;
  dwsp_host dwsp_host_i(.CLK_I(clk), .RST_I(rst), .LINK(link), .START_I(start), .TX_DATA_I(tx), .BUSY_O(busy),
    .DONE_O(done), .RX_DATA_O(rx));
  dwsp_device dwsp_device_i(.CLK_I(clk), .RST_I(rst), .LINK(link), .FIRST_WIPER_O(fw), .SECOND_WIPER_O(sw),
    .STACK_SEL_O(ss), .STACKED_WIPER_OUT_O(ow));
  dwsp_device dwsp_device_i2(.CLK_I(clk), .RST_I(rst), .LINK(rogue), .FIRST_WIPER_O(fw2), .SECOND_WIPER_O(sw2),
    .STACK_SEL_O(ss2), .STACKED_WIPER_OUT_O(ow2));
  dwsp_assertions dwsp_assertions_i(.CLK_I(clk), .RST_I(rst), .sel(link.sel), .sclk(link.sclk),
    .sdata(link.sdata), .cascade_out(link.cascade_out));
  function automatic logic [16:0] stk(input logic [16:0] d);
    return {9'h000, d[16] ? d[15:8] : d[7:0]};
  endfunction : stk
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic frame(input logic [16:0] d);
    @(posedge clk);
    tx <= d;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(posedge clk);
    chk({ss, sw, fw}, prev);
    chk({15'h0000, busy, link.sel}, 17'h00003);
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk);
    #1;
    chk(rx, prev);
    chk({15'h0000, busy, link.sel}, 17'h00000);
    repeat (2) @(posedge clk);
    #1;
    chk({ss, sw, fw}, d);
    chk({9'h000, ow}, stk(d));
    prev = d;
  endtask : frame
  // far-side driver for the second device, breaking the rules on request
  task automatic rogue_bits(input logic s, input int n, input logic [16:0] v);
    rogue.sel <= s;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      rogue.sclk <= 1'b0;
      rogue.sdata <= v[i];
      repeat (4) @(posedge clk);
      rogue.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    rogue.sclk <= 1'b0;
    repeat (4) @(posedge clk);
    rogue.sel <= 1'b0;
    rogue.sdata <= ~rogue.sdata;
    repeat (6) @(posedge clk);
    #1;
  endtask : rogue_bits
  initial begin
    logic [16:0] corners [4];
    logic [16:0] v;
    corners = '{17'h00000, 17'h1FFFF, 17'h10000, 17'h0FF00};
    rogue.sel = 1'b0;
    rogue.sclk = 1'b0;
    rogue.sdata = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({ss, sw, fw}, 17'h08080);
    rogue_bits(1'b0, 17, 17'h1A5C3);
    chk({ss2, sw2, fw2}, 17'h08080);
    v = 17'($random(seed));
    rogue_bits(1'b1, 5, v);
    chk({ss2, sw2, fw2}, {12'h080, v[4:0]});
    chk({9'h000, ow2}, stk({12'h080, v[4:0]}));
    for (int i = 0; i < 10; i++) frame(i < 4 ? corners[i] : 17'($random(seed)));
    tally_and_finish();
  end
  initial begin
    #250us;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_dual_wiper_serial_shift_port
